// file: design/psw_pkg.sv
// package for the pci slave window decode block: encodings, offsets, reset values
package psw_pkg;
  localparam int NWIN = 6;
  localparam int SYNC_STAGES = 3;
  // bus commands seen on the byte-enable lines during the address phase
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI = 4'hF;
  // configuration space dword indices
  localparam logic [5:0] CFG_IDENT = 6'h00;
  localparam logic [5:0] CFG_CLREV = 6'h02;
  localparam logic [5:0] CFG_BAR0 = 6'h04;
  localparam logic [5:0] CFG_SUBSYS = 6'h0B;
  localparam logic [5:0] CFG_INTLAT = 6'h0F;
  localparam logic [5:0] CFG_TRL0 = 6'h10;
  // local register indices
  localparam logic [5:0] LREG_TRL0 = 6'h00;
  localparam logic [5:0] LREG_MSK0 = 6'h08;
  localparam logic [5:0] LREG_BAR0 = 6'h10;
  localparam logic [5:0] LREG_CLREV = 6'h18;
  localparam logic [5:0] LREG_SUBSYS = 6'h19;
  localparam logic [5:0] LREG_INTLAT = 6'h1A;
  localparam logic [5:0] LREG_MST_TRL = 6'h1C;
  localparam logic [5:0] LREG_STATUS = 6'h1D;
  // base address layout
  localparam int BAR_PREF_BIT = 3;
  localparam logic [31:0] BAR_ADDR_FIELD = 32'hFFFF_FFF0;
  // reset values
  localparam logic [23:0] CLASS_RST = 24'h11_8000;
  localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;
  localparam logic [31:0] INTLAT_RST = 32'h0000_0000;
  localparam logic [31:0] MSK_8MB_PF = 32'hFF80_0008;
  localparam logic [31:0] MSK_64KB_NP = 32'hFFFF_0000;
  localparam logic [31:0] MSK_RST [NWIN] = '{MSK_8MB_PF, MSK_64KB_NP, MSK_64KB_NP, MSK_8MB_PF, MSK_8MB_PF,
                                            MSK_8MB_PF};
  // local targets: on-chip ram, memory-controller regs, chip regs, ram, ram, external memory
  localparam logic [31:0] TRL_RST [NWIN] = '{32'h1080_0000, 32'h2000_0000, 32'h0180_0000, 32'h1080_0000,
                                            32'h1080_0000, 32'h8000_0000};
  localparam logic [31:0] MST_TRL_RST = 32'h0000_0000;
  typedef enum logic [2:0] {SL_IDLE, SL_CFG, SL_MWR, SL_MRD, SL_WAIT} psw_slv_e;
  typedef enum logic [1:0] {LC_IDLE, LC_WR, LC_RD} psw_lcl_e;
endpackage : psw_pkg

// file: design/psw_top.sv
// pci slave window decode, configuration space and slave buffers
`timescale 1ns/1ns
`default_nettype none
// Operation
// - config identity defaults at reset, autoinit may replace
// - config access held off until initialisation done
// - separate read and write buffers, sixteen words
// - delayed prefetching reads, posted writes
// - six windows, each base, mask, translation
// - reset mapping of the six windows
// - translation and mask writable at any time
// - base register fields address, readahead_allowed_flag, type, size
// - memory space only, no io mapping
// - only 32-bit base addressing
// - host base writes gated by writable-bit mask
// - claim only window hits, translate, issue locally
// - local master claims within map, translates
// - translation, mask, base define window ends
// - translation writable locally and by host
// - replace masked upper bits with translation bits
// - unmatched bus address is ignored
// - mask readahead_allowed_flag enable shows as base bit 3
module psw_top import psw_pkg::*; #(
  parameter int BUF_DEPTH = 16,
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h00, // arbitrary value
  parameter logic [31:0] MST_MAP_BASE = 32'h3000_0000,
  parameter logic [31:0] MST_MAP_MASK = 32'hF000_0000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pci_clk,
  input wire logic pci_frame_b,
  input wire logic pci_irdy_b,
  input wire logic pci_idsel,
  input wire logic [3:0] pci_cbe,
  input wire logic [31:0] pci_ad_in,
  output logic [31:0] pci_ad_out,
  output logic pci_ad_oe_b,
  output logic pci_devsel_b_out,
  output logic pci_trdy_b_out,
  output logic pci_stop_b_out,
  output logic pci_tgt_oe_b,
  input wire logic autoinit_en,
  input wire logic autoinit_done,
  input wire logic reg_sel,
  input wire logic reg_we,
  input wire logic [5:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic sl_req,
  output logic sl_we,
  output logic [31:0] sl_addr,
  output logic [31:0] sl_wdata,
  input wire logic sl_ack,
  input wire logic [31:0] sl_rdata,
  input wire logic lm_req,
  input wire logic [31:0] lm_addr,
  output logic lm_claim,
  output logic [31:0] lm_pci_addr
);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int IW = 40;
  // indices wrap on a power of two; status word shows only five count bits
  if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("BUF_DEPTH out of range");
  end

  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    win_hit = (((a ^ b) & m & BAR_ADDR_FIELD) == 32'h0000_0000);
  endfunction : win_hit
  function automatic logic [31:0] xlate(input logic [31:0] a, input logic [31:0] t, input logic [31:0] m);
    xlate = (a & ~(m & BAR_ADDR_FIELD)) | (t & m & BAR_ADDR_FIELD);
  endfunction : xlate

  // three-stage pin synchroniser; stage one feeds only stage two
  logic [IW-1:0] s1_reg, s2_reg, s3_reg;
  logic pclk_lvl_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= {pci_clk, pci_frame_b, pci_irdy_b, pci_idsel, pci_cbe, pci_ad_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    // same level as the synchroniser reset, so no false edge follows reset
    if (!rst_b) pclk_lvl_reg <= 1'b1;
    else if (s2_reg[39] == s3_reg[39]) pclk_lvl_reg <= s3_reg[39];
  end
  logic pe;
  logic frame_a, irdy_a, idsel_s;
  logic [3:0] cbe_s;
  logic [31:0] ad_s;
  assign pe = s2_reg[39] && s3_reg[39] && !pclk_lvl_reg;
  assign frame_a = !s3_reg[38];
  assign irdy_a = !s3_reg[37];
  assign idsel_s = s3_reg[36];
  assign cbe_s = s3_reg[35:32];
  assign ad_s = s3_reg[31:0];

  // window register set
  logic [31:0] trl_reg [NWIN];
  logic [31:0] msk_reg [NWIN];
  logic [31:0] bar_reg [NWIN];
  logic [31:0] bar_rd [NWIN];
  logic [31:0] clrev_reg, subsys_reg, intlat_reg, mst_trl_reg;
  logic cfg_wr_go;
  logic [5:0] cfg_idx_reg;
  logic init_ready;
  assign init_ready = !autoinit_en || autoinit_done;
  genvar gw;
  generate
    for (gw = 0; gw < NWIN; gw++) begin : g_win
      // address from base, readahead_allowed_flag from mask, memory type and 32-bit size fixed at zero
      assign bar_rd[gw] = {bar_reg[gw][31:4], msk_reg[gw][BAR_PREF_BIT], 3'b000};
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          trl_reg[gw] <= TRL_RST[gw];
          msk_reg[gw] <= MSK_RST[gw];
          bar_reg[gw] <= 32'h0000_0000;
        end else begin
          if (reg_sel && reg_we && reg_idx == LREG_TRL0 + 6'(gw)) trl_reg[gw] <= reg_wdata;
          else if (cfg_wr_go && cfg_idx_reg == CFG_TRL0 + 6'(gw)) trl_reg[gw] <= ad_s;
          if (reg_sel && reg_we && reg_idx == LREG_MSK0 + 6'(gw)) msk_reg[gw] <= reg_wdata;
          if (cfg_wr_go && cfg_idx_reg == CFG_BAR0 + 6'(gw)) begin
            bar_reg[gw] <= (bar_reg[gw] & ~(msk_reg[gw] & BAR_ADDR_FIELD)) |
                           (ad_s & msk_reg[gw] & BAR_ADDR_FIELD);
          end
        end
      end
    end
  endgenerate

  // identity registers; local writes stand in for eeprom autoinit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clrev_reg <= {CLASS_RST, REVISION_ID};
      subsys_reg <= SUBSYS_RST;
      intlat_reg <= INTLAT_RST;
      mst_trl_reg <= MST_TRL_RST;
    end else if (reg_sel && reg_we) begin
      if (reg_idx == LREG_CLREV) clrev_reg <= reg_wdata;
      if (reg_idx == LREG_SUBSYS) subsys_reg <= reg_wdata;
      if (reg_idx == LREG_INTLAT) intlat_reg <= reg_wdata;
      if (reg_idx == LREG_MST_TRL) mst_trl_reg <= reg_wdata;
    end
  end

  // window decode, lowest window wins
  logic any_hit;
  logic [31:0] xl_addr;
  always_comb begin
    any_hit = 1'b0;
    xl_addr = 32'h0000_0000;
    for (int i = NWIN - 1; i >= 0; i--) begin
      if (win_hit(ad_s, bar_reg[i], msk_reg[i])) begin
        any_hit = 1'b1;
        xl_addr = xlate(ad_s, trl_reg[i], msk_reg[i]);
      end
    end
  end
  logic is_cfg, is_mwr, is_mrd;
  assign is_cfg = idsel_s && ad_s[1:0] == 2'b00 && (cbe_s == CMD_CFG_RD || cbe_s == CMD_CFG_WR) && init_ready;
  assign is_mwr = (cbe_s == CMD_MEM_WR || cbe_s == CMD_MEM_WRI) && ad_s[1:0] == 2'b00;
  assign is_mrd = (cbe_s == CMD_MEM_RD || cbe_s == CMD_MEM_RDM || cbe_s == CMD_MEM_RDL) && ad_s[1:0] == 2'b00;

  // config read data
  logic [31:0] cfg_rdata;
  always_comb begin
    cfg_rdata = 32'h0000_0000;
    if (cfg_idx_reg == CFG_IDENT) cfg_rdata = {DEVICE_ID, VENDOR_ID};
    if (cfg_idx_reg == CFG_CLREV) cfg_rdata = clrev_reg;
    if (cfg_idx_reg == CFG_SUBSYS) cfg_rdata = subsys_reg;
    if (cfg_idx_reg == CFG_INTLAT) cfg_rdata = intlat_reg;
    for (int i = 0; i < NWIN; i++) begin
      if (cfg_idx_reg == CFG_BAR0 + 6'(i)) cfg_rdata = bar_rd[i];
      if (cfg_idx_reg == CFG_TRL0 + 6'(i)) cfg_rdata = trl_reg[i];
    end
  end

  // slave buffers and bus-side state machine
  logic [31:0] wbuf [BUF_DEPTH];
  logic [31:0] rbuf [BUF_DEPTH];
  logic [CW-1:0] wcnt_reg, rfill_reg, ridx_reg, wdrain_reg;
  logic [31:0] wbase_reg, dr_pci_reg, dr_loc_reg;
  logic wcommit_reg, dr_valid_reg, cfg_wr_reg, drain_done;
  psw_slv_e slv_st;
  logic rd_ready;
  assign rd_ready = dr_valid_reg && rfill_reg == CW'(BUF_DEPTH);
  assign cfg_wr_go = pe && slv_st == SL_CFG && irdy_a && cfg_wr_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slv_st <= SL_IDLE;
      {pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b, pci_ad_oe_b} <= 5'h1F;
      pci_ad_out <= 32'h0000_0000;
      cfg_idx_reg <= 6'h00;
      cfg_wr_reg <= 1'b0;
      wcnt_reg <= '0;
      ridx_reg <= '0;
      wbase_reg <= 32'h0000_0000;
      wcommit_reg <= 1'b0;
      dr_valid_reg <= 1'b0;
      dr_pci_reg <= 32'h0000_0000;
      dr_loc_reg <= 32'h0000_0000;
    end else begin
      if (drain_done) begin
        wcnt_reg <= '0;
        wcommit_reg <= 1'b0;
      end
      // config data must stand before the host samples the data edge
      if (slv_st == SL_CFG) pci_ad_out <= cfg_rdata;
      if (pe) begin
        unique case (slv_st)
          SL_IDLE: if (frame_a) begin
            if (is_cfg) begin
              slv_st <= SL_CFG;
              cfg_idx_reg <= ad_s[7:2];
              cfg_wr_reg <= cbe_s == CMD_CFG_WR;
              {pci_devsel_b_out, pci_trdy_b_out, pci_tgt_oe_b} <= 3'b000;
              pci_ad_oe_b <= cbe_s == CMD_CFG_WR;
            end else if (is_mwr && any_hit && wcnt_reg == '0 && !wcommit_reg) begin
              slv_st <= SL_MWR;
              wbase_reg <= xl_addr;
              {pci_devsel_b_out, pci_trdy_b_out, pci_tgt_oe_b} <= 3'b000;
            end else if (is_mrd && any_hit) begin
              {pci_devsel_b_out, pci_tgt_oe_b} <= 2'b00;
              if (rd_ready && dr_pci_reg == ad_s) begin
                slv_st <= SL_MRD;
                pci_trdy_b_out <= 1'b0;
                pci_ad_oe_b <= 1'b0;
                pci_ad_out <= rbuf[0];
                ridx_reg <= CW'(1);
              end else begin
                // delayed read: retry now, readahead_allowed_flag behind the retry
                slv_st <= SL_WAIT;
                pci_stop_b_out <= 1'b0;
                if (!dr_valid_reg || rd_ready) begin
                  dr_valid_reg <= 1'b1;
                  dr_pci_reg <= ad_s;
                  dr_loc_reg <= xl_addr;
                end
              end
            end
          end
          SL_CFG: if (irdy_a) begin
            pci_ad_out <= cfg_rdata;
            if (frame_a) begin
              {pci_trdy_b_out, pci_stop_b_out} <= 2'b10;
              slv_st <= SL_WAIT;
            end else begin
              {pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b, pci_ad_oe_b} <= 5'h1F;
              slv_st <= SL_IDLE;
            end
          end else begin
            pci_ad_out <= cfg_rdata;
          end
          SL_MWR: if (irdy_a) begin
            wbuf[wcnt_reg[CW-2:0]] <= ad_s;
            wcnt_reg <= wcnt_reg + CW'(1);
            if (!frame_a) begin
              wcommit_reg <= 1'b1;
              {pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b} <= 4'hF;
              slv_st <= SL_IDLE;
            end else if (wcnt_reg == CW'(BUF_DEPTH - 1)) begin
              wcommit_reg <= 1'b1;
              {pci_trdy_b_out, pci_stop_b_out} <= 2'b10; // buffer full, disconnect
              slv_st <= SL_WAIT;
            end
          end
          SL_MRD: if (irdy_a) begin
            if (!frame_a) begin
              dr_valid_reg <= 1'b0;
              {pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b, pci_ad_oe_b} <= 5'h1F;
              slv_st <= SL_IDLE;
            end else if (ridx_reg == CW'(BUF_DEPTH)) begin
              dr_valid_reg <= 1'b0;
              {pci_trdy_b_out, pci_stop_b_out} <= 2'b10;
              slv_st <= SL_WAIT;
            end else begin
              pci_ad_out <= rbuf[ridx_reg[CW-2:0]];
              ridx_reg <= ridx_reg + CW'(1);
            end
          end
          SL_WAIT: if (!frame_a && irdy_a) begin
            {pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b, pci_ad_oe_b} <= 5'h1F;
            slv_st <= SL_IDLE;
          end
        endcase
      end
    end
  end

  // local side: drain posted writes first, then readahead_allowed_flag
  psw_lcl_e lcl_st;
  assign drain_done = lcl_st == LC_WR && sl_ack && wdrain_reg == wcnt_reg - CW'(1);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lcl_st <= LC_IDLE;
      wdrain_reg <= '0;
      rfill_reg <= '0;
    end else begin
      if (pe && slv_st == SL_IDLE && frame_a && is_mrd && any_hit && (!dr_valid_reg || rd_ready) &&
          !(rd_ready && dr_pci_reg == ad_s)) rfill_reg <= '0;
      unique case (lcl_st)
        LC_IDLE: if (wcommit_reg && wcnt_reg != '0) begin
          lcl_st <= LC_WR;
          wdrain_reg <= '0;
        end else if (dr_valid_reg && rfill_reg != CW'(BUF_DEPTH)) begin
          lcl_st <= LC_RD;
        end
        LC_WR: if (sl_ack) begin
          wdrain_reg <= wdrain_reg + CW'(1);
          if (drain_done) lcl_st <= LC_IDLE;
        end
        LC_RD: if (sl_ack) begin
          rbuf[rfill_reg[CW-2:0]] <= sl_rdata;
          rfill_reg <= rfill_reg + CW'(1);
          lcl_st <= LC_IDLE;
        end
      endcase
    end
  end
  assign sl_req = lcl_st != LC_IDLE;
  assign sl_we = lcl_st == LC_WR;
  assign sl_addr = sl_we ? wbase_reg + 32'({wdrain_reg, 2'b00}) : dr_loc_reg + 32'({rfill_reg, 2'b00});
  assign sl_wdata = wbuf[wdrain_reg[CW-2:0]];

  // local master claim and translation
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lm_claim <= 1'b0;
      lm_pci_addr <= 32'h0000_0000;
    end else begin
      lm_claim <= lm_req && ((lm_addr & MST_MAP_MASK) == MST_MAP_BASE);
      lm_pci_addr <= (lm_addr & ~MST_MAP_MASK) | (mst_trl_reg & MST_MAP_MASK);
    end
  end

  // local register read
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (reg_idx == LREG_CLREV) reg_rdata = clrev_reg;
    if (reg_idx == LREG_SUBSYS) reg_rdata = subsys_reg;
    if (reg_idx == LREG_INTLAT) reg_rdata = intlat_reg;
    if (reg_idx == LREG_MST_TRL) reg_rdata = mst_trl_reg;
    if (reg_idx == LREG_STATUS) reg_rdata = {23'h00_0000, init_ready, rd_ready, dr_valid_reg, wcommit_reg, 5'(wcnt_reg)};
    for (int i = 0; i < NWIN; i++) begin
      if (reg_idx == LREG_TRL0 + 6'(i)) reg_rdata = trl_reg[i];
      if (reg_idx == LREG_MSK0 + 6'(i)) reg_rdata = msk_reg[i];
      if (reg_idx == LREG_BAR0 + 6'(i)) reg_rdata = bar_rd[i];
    end
  end

  a_miss_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pe && slv_st == SL_IDLE && frame_a && !is_cfg && !any_hit) |=> pci_tgt_oe_b)
    else $error("unmatched address claimed");
  a_claim_on_hit: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(pci_tgt_oe_b) |-> $past(any_hit || is_cfg))
    else $error("claim without window hit");
  a_bar_masked_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((bar_reg[0] ^ $past(bar_reg[0])) & ~$past(msk_reg[0])) == 32'h0000_0000)
    else $error("protected base bit changed");
  a_bar_low_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pe && slv_st == SL_CFG && cfg_idx_reg == CFG_BAR0) |=> pci_ad_out[3:0] == {msk_reg[0][3], 3'b000})
    else $error("base low bits wrong");
  a_wbase_xlate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pe && slv_st == SL_IDLE && frame_a && is_mwr && any_hit && wcnt_reg == '0 && !wcommit_reg)
      |=> wbase_reg == $past(xl_addr) && slv_st == SL_MWR)
    else $error("write base not translated");
  a_wbuf_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
    wcnt_reg <= CW'(BUF_DEPTH) && rfill_reg <= CW'(BUF_DEPTH))
    else $error("buffer overrun");
  a_read_retry: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pe && slv_st == SL_IDLE && frame_a && !is_cfg && is_mrd && any_hit && !rd_ready)
      |=> !pci_stop_b_out && pci_trdy_b_out && dr_valid_reg)
    else $error("delayed read not retried");
  a_cfg_held: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(slv_st == SL_CFG) |-> $past(init_ready))
    else $error("config claimed before init");
  a_msk_anytime: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_sel && reg_we && reg_idx == LREG_MSK0) |=> msk_reg[0] == $past(reg_wdata))
    else $error("mask write lost");
  a_mst_claim: assert property (@(posedge core_clk) disable iff (!rst_b)
    lm_claim |-> $past(lm_req) && ($past(lm_addr) & MST_MAP_MASK) == MST_MAP_BASE)
    else $error("master claim outside map");
endmodule : psw_top
`default_nettype wire

// file: bench/psw_host_model.sv
// bus host model: address and data phases, samples the target's answers
`timescale 1ns/1ns
`default_nettype none
module psw_host_model (
  input wire logic core_clk,
  input wire logic rst_b,
  output logic pci_clk,
  output logic pci_frame_b,
  output logic pci_irdy_b,
  output logic pci_idsel,
  output logic [3:0] pci_cbe,
  output logic [31:0] pci_ad_in,
  input wire logic [31:0] pci_ad_out,
  input wire logic pci_ad_oe_b,
  input wire logic pci_devsel_b_out,
  input wire logic pci_trdy_b_out,
  input wire logic pci_stop_b_out,
  input wire logic pci_tgt_oe_b
);
  logic [31:0] ad_reg = 32'h0;
  logic drv = 1'b0;
  // released lines show the inverse, so a held copy never passes
  assign pci_ad_in = !pci_ad_oe_b ? pci_ad_out : drv ? ad_reg : ~ad_reg;
  initial begin
    pci_clk = 1'b0;
    pci_frame_b = 1'b1;
    pci_irdy_b = 1'b1;
    pci_idsel = 1'b0;
    pci_cbe = 4'h0;
  end
  task automatic half;
    repeat (4) @(posedge core_clk);
  endtask : half
  // clock only runs inside a transfer; resp 0 none, 1 data, 2 stop
  task automatic txn(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd, input logic sel,
                     output logic [31:0] rd, output logic [1:0] resp);
    resp = 2'd0;
    rd = 32'h0;
    wait (rst_b === 1'b1);
    half;
    pci_frame_b <= 1'b0;
    pci_cbe <= cmd;
    ad_reg <= addr;
    drv <= 1'b1;
    pci_idsel <= sel;
    half;
    pci_clk <= 1'b1;
    half;
    pci_clk <= 1'b0;
    pci_frame_b <= 1'b1;
    pci_irdy_b <= 1'b0;
    pci_cbe <= 4'h0;
    ad_reg <= wd;
    drv <= cmd[0];
    for (int i = 0; i < 4 && resp == 2'd0; i++) begin
      half;
      pci_clk <= 1'b1;
      if (!pci_tgt_oe_b && !pci_devsel_b_out && !pci_trdy_b_out) begin
        resp = 2'd1;
        rd = pci_ad_in;
      end else if (!pci_tgt_oe_b && !pci_devsel_b_out && !pci_stop_b_out) begin
        resp = 2'd2;
      end
      half;
      pci_clk <= 1'b0;
    end
    pci_irdy_b <= 1'b1;
    drv <= 1'b0;
    pci_idsel <= 1'b0;
    half;
    pci_clk <= 1'b1;
    half;
    pci_clk <= 1'b0;
  endtask : txn
endmodule : psw_host_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench: identity, window registers, decode and translation
`timescale 1ns/1ns
`default_nettype none
module tb_top import psw_pkg::*;;
  localparam logic [31:0] MB = 32'h3000_0000;
  localparam logic [7:0] REV = 8'h5c; // arbitrary value
  logic core_clk = 1'b0, rst_b = 1'b0, pci_clk, pci_frame_b, pci_irdy_b, pci_idsel;
  logic [3:0] pci_cbe;
  logic [31:0] pci_ad_in, pci_ad_out, reg_wdata = 32'h0, reg_rdata, sl_addr, sl_wdata, sl_rdata = 32'h0;
  logic pci_ad_oe_b, pci_devsel_b_out, pci_trdy_b_out, pci_stop_b_out, pci_tgt_oe_b, sl_req, sl_we, lm_claim;
  logic autoinit_en = 1'b1, autoinit_done = 1'b0, reg_sel = 1'b0, reg_we = 1'b0, sl_ack = 1'b0, lm_req = 1'b0;
  logic [5:0] reg_idx = 6'h0;
  logic [31:0] lm_addr = 32'h0, lm_pci_addr, w_addr, w_data, r_addr0, d, m, w;
  logic [31:0] bar_old [NWIN] = '{default: 32'h0};
  logic [1:0] resp;
  int fails = 0, checks = 0, rd_cnt = 0, wr_cnt = 0, cyc = 0;
  psw_top #(.REVISION_ID(REV), .MST_MAP_BASE(MB)) u_dut (.core_clk, .rst_b, .pci_clk, .pci_frame_b, .pci_irdy_b,
    .pci_idsel, .pci_cbe, .pci_ad_in, .pci_ad_out, .pci_ad_oe_b, .pci_devsel_b_out, .pci_trdy_b_out,
    .pci_stop_b_out, .pci_tgt_oe_b, .autoinit_en, .autoinit_done, .reg_sel, .reg_we, .reg_idx, .reg_wdata,
    .reg_rdata, .sl_req, .sl_we, .sl_addr, .sl_wdata, .sl_ack, .sl_rdata, .lm_req, .lm_addr, .lm_claim,
    .lm_pci_addr);
  psw_host_model u_host (.core_clk, .rst_b, .pci_clk, .pci_frame_b, .pci_irdy_b, .pci_idsel, .pci_cbe,
    .pci_ad_in, .pci_ad_out, .pci_ad_oe_b, .pci_devsel_b_out, .pci_trdy_b_out, .pci_stop_b_out, .pci_tgt_oe_b);
  always #25 core_clk = ~core_clk;
  function automatic logic [31:0] rfn(input logic [31:0] a);
    return {a[15:0], a[31:16]};
  endfunction : rfn
  function automatic logic [31:0] xl(input logic [31:0] a, input logic [31:0] mk, input logic [31:0] t);
    return (a & ~(mk & BAR_ADDR_FIELD)) | (t & mk & BAR_ADDR_FIELD);
  endfunction : xl
  // interconnect stand-in: acks after a random stall
  always @(posedge core_clk) begin
    if (sl_req && !sl_ack && $urandom_range(1) == 1) begin
      sl_ack <= 1'b1;
      sl_rdata <= rfn(sl_addr);
      if (sl_we) begin
        wr_cnt <= wr_cnt + 1;
        w_addr <= sl_addr;
        w_data <= sl_wdata;
      end else begin
        if (rd_cnt == 0) r_addr0 <= sl_addr;
        rd_cnt <= rd_cnt + 1;
      end
    end else begin
      sl_ack <= 1'b0;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] i, input logic [31:0] v);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_we <= 1'b1;
    reg_idx <= i;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_sel <= 1'b0;
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] i, output logic [31:0] v);
    @(posedge core_clk);
    reg_idx <= i;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd
  task automatic cfg(input logic [3:0] c, input logic [5:0] i, input logic [31:0] v, output logic [31:0] r);
    u_host.txn(c, {24'h0, i, 2'b00}, v, 1'b1, r, resp);
  endtask : cfg
  task results;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // run should need about 1100 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      results;
    end
  end
  initial begin
    void'($urandom(32'h4fa5_3117));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(LREG_CLREV, d);
    chk(d, {CLASS_RST, REV});
    rd(LREG_SUBSYS, d);
    chk(d, SUBSYS_RST);
    rd(LREG_INTLAT, d);
    chk(d, INTLAT_RST);
    for (int i = 0; i < NWIN; i++) begin
      rd(6'(LREG_MSK0 + i), d);
      chk(d, MSK_RST[i]);
      rd(6'(LREG_TRL0 + i), d);
      chk(d, TRL_RST[i]);
      rd(6'(LREG_BAR0 + i), d);
      chk(d, {28'h0, MSK_RST[i][3], 3'b000});
    end
    rd(6'h3F, d);
    chk(d, 32'h0);
    $display("test reset_defaults done");
    // identity load: host held off until the load is finished
    cfg(CMD_CFG_RD, CFG_CLREV, 32'h0, d);
    chk({30'h0, resp}, 32'h0);
    wr(LREG_CLREV, 32'h0780_0102);
    autoinit_done <= 1'b1;
    cfg(CMD_CFG_RD, CFG_CLREV, 32'h0, d);
    chk(d, 32'h0780_0102);
    cfg(CMD_CFG_RD, CFG_INTLAT, 32'h0, d);
    chk(d, INTLAT_RST);
    $display("test autoinit done");
    for (int i = 0; i < NWIN; i++) begin
      m = (i == 0) ? 32'h0 : $urandom();
      w = $urandom();
      wr(6'(LREG_MSK0 + i), m);
      cfg(CMD_CFG_WR, 6'(CFG_BAR0 + i), w, d);
      bar_old[i] = ((bar_old[i] & ~m) | (w & m)) & BAR_ADDR_FIELD;
      cfg(CMD_CFG_RD, 6'(CFG_BAR0 + i), 32'h0, d);
      chk(d, bar_old[i] | {28'h0, m[3], 3'b000});
    end
    for (int i = 0; i < NWIN; i++) begin
      wr(6'(LREG_MSK0 + i), MSK_RST[i]);
      cfg(CMD_CFG_WR, 6'(CFG_BAR0 + i), (i == 0) ? 32'h1280_0000 : 32'h0, d);
    end
    $display("test base_protect done");
    for (int k = 0; k < 2; k++) begin
      w = $urandom();
      u_host.txn(k ? CMD_MEM_WRI : CMD_MEM_WR, 32'h1280_ABC0, w, 1'b0, d, resp);
      chk({30'h0, resp}, 32'h1);
      for (int j = 0; j < 200 && wr_cnt <= k; j++) @(posedge core_clk);
      chk(32'(wr_cnt), 32'(k + 1));
      chk(w_addr, xl(32'h1280_ABC0, MSK_8MB_PF, k ? 32'h2000_0000 : TRL_RST[0]));
      chk(w_data, w);
      cfg(CMD_CFG_WR, CFG_TRL0, 32'h2000_0000, d);
    end
    rd(LREG_TRL0, d);
    chk(d, 32'h2000_0000);
    u_host.txn(CMD_MEM_WR, 32'h7000_0000, 32'h0, 1'b0, d, resp);
    chk({30'h0, resp}, 32'h0);
    u_host.txn(CMD_MEM_RD, 32'h7000_0040, 32'h0, 1'b0, d, resp);
    chk({30'h0, resp}, 32'h0);
    $display("test posted_write done");
    wr(LREG_TRL0, TRL_RST[0]);
    u_host.txn(CMD_MEM_RDL, 32'h1280_0100, 32'h0, 1'b0, d, resp);
    chk({30'h0, resp}, 32'h2);
    for (int j = 0; j < 600 && rd_cnt < 16; j++) @(posedge core_clk);
    repeat (40) @(posedge core_clk);
    chk(32'(rd_cnt), 32'd16);
    chk(r_addr0, xl(32'h1280_0100, MSK_8MB_PF, TRL_RST[0]));
    u_host.txn(CMD_MEM_RDM, 32'h1280_0100, 32'h0, 1'b0, d, resp);
    chk({30'h0, resp}, 32'h1);
    chk(d, rfn(32'h1080_0100));
    rd(LREG_STATUS, d);
    chk(d, 32'h0000_0100);
    $display("test delayed_read done");
    wr(LREG_MST_TRL, 32'hA000_0000);
    for (int k = 0; k < 8; k++) begin
      w = $urandom();
      if (k < 2) w[31:28] = k ? 4'h3 : 4'h2;
      @(posedge core_clk);
      lm_req <= 1'b1;
      lm_addr <= w;
      @(posedge core_clk);
      @(negedge core_clk);
      chk({31'h0, lm_claim}, {31'h0, (w & 32'hF000_0000) == MB});
      chk(lm_pci_addr, (w & 32'h0FFF_FFFF) | 32'hA000_0000);
    end
    lm_req <= 1'b0;
    $display("test master_claim done");
    results;
  end
endmodule : tb_top
`default_nettype wire
